// File: verilog/atc_timer.sv
/*
  Four-channel timer core: 16-bit counter (up, down, center-aligned),
  repetition-controlled update events, shadow reload, input capture, output
  compare and PWM prepare signals, with APB register access.
  Assumes a single clock pclk, channel pins asynchronous to it, and a
  complementary output stage downstream of channel_prepare_signal.
*/
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "atc_defines.svh"

// What this block does
// - Down mode counts from auto-reload to 0, reloads, flags underflow.
// - Update event only after repetition value plus one overflows or underflows.
// - Down mode software update loads auto-reload and makes update event.
// - Update disable blocks updates; updates copy repetition, reload, prescaler shadows.
// - Center mode counts 0 up to auto-reload then back down to 0.
// - Center mode overflow at reload minus one going up, underflow at one down.
// - Direction bit read-only in center mode, shows current direction.
// - Center mode software update clears counter and makes update event.
// - Update flag set on the update event that overflows and underflows produce in center mode.
// - Repetition counter decrements on each overflow and underflow.
// - Software update reloads the repetition counter.
// - New repetition value acts from next update event only.
// - Selected input edge captures counter, sets channel flag, requests interrupt.
// - Input synchronised, filtered, edge-detected by polarity; pin or XOR of three.
// - Capture source own, neighbour or trigger; prescaler merges input events.
// - Input mode channels ignore software writes to channel value.
// - Capture while channel flag set also sets over-capture flag.
// - Requests gated by enables; software generate bit requests directly.
// - Compare match sets, clears or toggles prepare signal and sets flag.
// - Compare codes 110 and 111 select the two PWM modes.
// - Edge PWM period from reload; center PWM twice reload and value.
// - Up mode, value above reload: PWM0 always inactive, PWM1 always active.
// - Up mode counts 0 to auto-reload, restarts at 0, flags overflow.
// - Prescaler divides 1 to 65536; new value acts at next update.
module atc_timer
  import atc_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int CNT_W  = 16,
  parameter int REP_W  = 8
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  ch_in,
  input  wire logic        int_trigger,
  output logic [3:0]       channel_prepare_signal,
  output logic [3:0]       ch_int_req,
  output logic [3:0]       ch_dma_req,
  output logic             upd_int_req,
  output logic             update_event
);

  localparam atc_state_t RST = '{car_act: `ATC_CAR_RST, car_pend: `ATC_CAR_RST, default: '0};

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // The state struct fixes these sizes; other values cannot be served
  if (NUM_CH != 4)
  begin : g_bad_num_ch
    $error("atc_timer: NUM_CH must be 4");
  end
  if (CNT_W != 16)
  begin : g_bad_cnt_w
    $error("atc_timer: CNT_W must be 16");
  end
  if (REP_W != 8)
  begin : g_bad_rep_w
    $error("atc_timer: REP_W must be 8");
  end

  atc_state_t s;
  atc_state_t n;
  logic        wr;
  logic        hit;
  logic        sw_update_generate;
  logic        tick;
  logic        center;
  logic        ovf;
  logic        unf;
  logic        upd_hw;
  logic        upd;
  logic        itr_rise;
  logic [3:0]  raw;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [3:0]  sel_ev;
  logic [3:0]  cap;
  logic [3:0]  cmpm;
  logic [3:0]  chg;
  logic [2:0]  icp_lim;
  logic [31:0] rdv;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign hit     = (paddr[1:0] == 2'h0) && (paddr[7:4] <= `ATC_CHCV_HI);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr      = psel & penable & pwrite & hit;
  assign sw_update_generate     = wr && (paddr == `ATC_SWEVG) && pwdata[0];
  assign chg     = (wr && (paddr == `ATC_SWEVG)) ? pwdata[4:1] : 4'h0;

  always_comb
  begin
    rdv = 32'h0;
    if (paddr[7:4] == `ATC_CHCTL_HI)
      rdv = {17'h0, s.chctl[paddr[3:2]]};
    else if (paddr[7:4] == `ATC_CHCV_HI)
      rdv = {16'h0, s.cv_pend[paddr[3:2]]};
    else
      case (paddr)
        `ATC_CTL:   rdv = {25'h0, s.center_align_select, s.dir, 2'h0, s.update_disable, s.counter_enable};
        `ATC_INTF:  rdv = {19'h0, s.chof, 4'h0, s.chf, s.uif};
        `ATC_INTEN: rdv = {19'h0, s.chde, 4'h0, s.chie, s.uie};
        `ATC_CNT:   rdv = {16'h0, s.cnt};
        `ATC_PSC:   rdv = {16'h0, s.psc_pend};
        `ATC_CAR:   rdv = {16'h0, s.car_pend};
        `ATC_REPETITION_VALUE:  rdv = {24'h0, s.rep_pend};
        default:    rdv = 32'h0;
      endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    n        = s;
    ovf      = 1'b0;
    unf      = 1'b0;
    upd_hw   = 1'b0;
    raw      = 4'h0;
    rise     = 4'h0;
    fall     = 4'h0;
    sel_ev   = 4'h0;
    cap      = 4'h0;
    cmpm     = 4'h0;
    icp_lim  = 3'h0;
    center   = (s.center_align_select != 2'h0);
    itr_rise = s.sy2[4] & ~s.itr_d;
    n.upd    = 1'b0;

    // Read data is latched in the setup cycle so it stands through the access phase
    if (psel && !penable && !pwrite)
      n.prdata = rdv;

    // Configuration writes; flags clear by writing zero
    if (wr)
      case (paddr)
        `ATC_CTL:
        begin
          n.counter_enable   = pwdata[0];
          n.update_disable = pwdata[1];
          n.center_align_select   = pwdata[6:5];
          if (!center && pwdata[6:5] == 2'h0)
            n.dir = pwdata[4];
        end
        `ATC_INTF:
        begin
          n.uif  = s.uif & pwdata[0];
          n.chf  = s.chf & pwdata[4:1];
          n.chof = s.chof & pwdata[12:9];
        end
        `ATC_INTEN:
        begin
          n.uie  = pwdata[0];
          n.chie = pwdata[4:1];
          n.chde = pwdata[12:9];
        end
        `ATC_PSC:  n.psc_pend = pwdata[15:0];
        `ATC_CAR:  n.car_pend = pwdata[15:0];
        `ATC_REPETITION_VALUE: n.rep_pend = pwdata[7:0];
        default:   n.counter_enable = n.counter_enable;
      endcase

    // Prescaler and counter
    tick = s.counter_enable && (s.psc_cnt == s.psc_act);
    if (s.counter_enable)
      n.psc_cnt = tick ? 16'h0 : s.psc_cnt + 16'h1;
    if (tick)
    begin
      if (center)
      begin
        if (s.dir)
        begin
          if (s.cnt == 16'h1)
          begin
            n.cnt = 16'h0;
            n.dir = 1'b0;
            unf   = 1'b1;
          end
          else
            n.cnt = s.cnt - 16'h1;
        end
        else if (s.cnt == s.car_act - 16'h1)
        begin
          n.cnt = s.car_act;
          n.dir = 1'b1;
          ovf   = 1'b1;
        end
        else
          n.cnt = s.cnt + 16'h1;
      end
      else if (s.dir)
      begin
        if (s.cnt == 16'h0)
        begin
          n.cnt = s.car_act;
          unf   = 1'b1;
        end
        else
          n.cnt = s.cnt - 16'h1;
      end
      else if (s.cnt == s.car_act)
      begin
        n.cnt = 16'h0;
        ovf   = 1'b1;
      end
      else
        n.cnt = s.cnt + 16'h1;
    end

    // Repetition and update events
    if (ovf || unf)
    begin
      if (s.rep_cnt == 8'h0)
      begin
        upd_hw    = 1'b1;
        n.rep_cnt = s.rep_act;
      end
      else
        n.rep_cnt = s.rep_cnt - 8'h1;
    end
    // Update disable also swallows software updates; the counter still reloads
    upd = (upd_hw || sw_update_generate) && !s.update_disable;
    if (sw_update_generate)
    begin
      n.rep_cnt = s.rep_pend;
      n.psc_cnt = 16'h0;
      n.cnt     = (!center && s.dir) ? s.car_pend : 16'h0;
      if (center)
        n.dir = 1'b0;
    end
    if (upd)
    begin
      n.car_act = s.car_pend;
      n.psc_act = s.psc_pend;
      n.rep_act = s.rep_pend;
      n.rep_cnt = s.rep_pend;
      n.uif     = 1'b1;
      n.upd     = 1'b1;
    end
    if (wr && paddr == `ATC_CNT)
      n.cnt = pwdata[15:0];

    // Channel input stage
    n.sy1   = {int_trigger, ch_in};
    n.sy2   = s.sy1;
    n.itr_d = s.sy2[4];
    for (int i = 0; i < NUM_CH; i++)
    begin
      raw[i] = s.chctl[i][`ATC_CC_XOR] ? ^s.sy2[2:0] : s.sy2[i];
      // Filter follows only after capture_filter+1 differing samples
      if (raw[i] == s.flt_lvl[i])
        n.flt_cnt[i] = 4'h0;
      else if (s.flt_cnt[i] >= s.chctl[i][`ATC_CC_FLT])
      begin
        n.flt_lvl[i] = raw[i];
        n.flt_cnt[i] = 4'h0;
      end
      else
        n.flt_cnt[i] = s.flt_cnt[i] + 4'h1;
      rise[i] = n.flt_lvl[i] & ~s.flt_lvl[i];
      fall[i] = ~n.flt_lvl[i] & s.flt_lvl[i];
    end

    // Channel capture, compare and requests
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (wr && paddr[7:4] == `ATC_CHCTL_HI && paddr[3:2] == 2'(i))
        n.chctl[i] = pwdata[14:0];
      case (s.chctl[i][`ATC_CC_MS])
        `ATC_MS_OWN: sel_ev[i] = s.chctl[i][`ATC_CC_POL] ? fall[i] : rise[i];
        `ATC_MS_NBR: sel_ev[i] = s.chctl[i][`ATC_CC_POL] ? fall[i ^ 1] : rise[i ^ 1];
        `ATC_MS_TRG: sel_ev[i] = itr_rise;
        default:     sel_ev[i] = 1'b0;
      endcase
      icp_lim = (3'h1 << s.chctl[i][`ATC_CC_ICP]) - 3'h1;
      if (sel_ev[i] && s.chctl[i][`ATC_CC_EN])
      begin
        if (s.icp_cnt[i] == icp_lim)
        begin
          cap[i]       = 1'b1;
          n.icp_cnt[i] = 3'h0;
        end
        else
          n.icp_cnt[i] = s.icp_cnt[i] + 3'h1;
      end
      if (wr && paddr[7:4] == `ATC_CHCV_HI && paddr[3:2] == 2'(i)
          && s.chctl[i][`ATC_CC_MS] == `ATC_MS_OUT)
      begin
        n.cv_pend[i] = pwdata[15:0];
        if (!s.chctl[i][`ATC_CC_SEN])
          n.cv_act[i] = pwdata[15:0];
      end
      if (upd && s.chctl[i][`ATC_CC_SEN])
        n.cv_act[i] = s.cv_pend[i];
      if (cap[i])
      begin
        n.cv_act[i]  = s.cnt;
        n.cv_pend[i] = s.cnt;
      end
      if (s.chctl[i][`ATC_CC_MS] == `ATC_MS_OUT)
      begin
        // Match on the value the tick produces, so each counter step flags once
        cmpm[i] = tick && (n.cnt == s.cv_act[i]);
        case (s.chctl[i][`ATC_CC_CMP])
          `ATC_OC_SET:  n.prep[i] = s.prep[i] | cmpm[i];
          `ATC_OC_CLR:  n.prep[i] = s.prep[i] & ~cmpm[i];
          `ATC_OC_TGL:  n.prep[i] = s.prep[i] ^ cmpm[i];
          `ATC_OC_FLO:  n.prep[i] = 1'b0;
          `ATC_OC_FHI:  n.prep[i] = 1'b1;
          `ATC_OC_PWM0: n.prep[i] = (n.cnt >= s.cv_act[i]);
          `ATC_OC_PWM1: n.prep[i] = (n.cnt < s.cv_act[i]);
          default:      n.prep[i] = s.prep[i];
        endcase
      end
      // Hardware sets come last so they win over a clear written in the same cycle
      if (cap[i] && s.chf[i])
        n.chof[i] = 1'b1;
      if (cap[i] || cmpm[i] || chg[i])
        n.chf[i] = 1'b1;
      n.dma[i] = (cap[i] || cmpm[i] || chg[i]) && s.chde[i];
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // All state resets at once; only the reload registers leave reset nonzero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= RST;
    else
      s <= n;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata                 = s.prdata;
  assign channel_prepare_signal = s.prep;
  assign ch_int_req             = s.chf & s.chie;
  assign ch_dma_req             = s.dma;
  assign upd_int_req            = s.uif & s.uie;
  assign update_event           = s.upd;

endmodule : atc_timer

// File: inc/atc_defines.svh
/*
  Register offsets, field positions, reset values and mode codes of the
  four-channel timer core. Assumes byte addresses on an APB bus with 32-bit data.
*/
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ATC_CTL      8'h00
`define ATC_INTF     8'h04
`define ATC_INTEN    8'h08
`define ATC_SWEVG    8'h0c
`define ATC_CNT      8'h10
`define ATC_PSC      8'h14
`define ATC_CAR      8'h18
`define ATC_REPETITION_VALUE     8'h1c
`define ATC_CHCTL_HI 4'h2
`define ATC_CHCV_HI  4'h3

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define ATC_CC_MS    1:0
`define ATC_CC_CMP   4:2
`define ATC_CC_SEN   5
`define ATC_CC_POL   6
`define ATC_CC_EN    7
`define ATC_CC_FLT   11:8
`define ATC_CC_ICP   13:12
`define ATC_CC_XOR   14
`define ATC_CAR_RST  16'hffff

// ----------------------------------------------------------------------------
// Channel mode select and compare mode codes
// ----------------------------------------------------------------------------
`define ATC_MS_OUT   2'h0
`define ATC_MS_OWN   2'h1
`define ATC_MS_NBR   2'h2
`define ATC_MS_TRG   2'h3
`define ATC_OC_HOLD  3'h0
`define ATC_OC_SET   3'h1
`define ATC_OC_CLR   3'h2
`define ATC_OC_TGL   3'h3
`define ATC_OC_FLO   3'h4
`define ATC_OC_FHI   3'h5
`define ATC_OC_PWM0  3'h6
`define ATC_OC_PWM1  3'h7

`endif

// File: inc/atc_pkg.sv
/*
  Types of the timer core: the whole register state as one packed struct.
  Assumes the constants of atc_defines.svh.
*/
package atc_pkg;

  typedef struct packed {
    logic [15:0]       cnt;
    logic [15:0]       psc_cnt;
    logic [15:0]       psc_act;
    logic [15:0]       psc_pend;
    logic [15:0]       car_act;
    logic [15:0]       car_pend;
    logic [7:0]        rep_cnt;
    logic [7:0]        rep_act;
    logic [7:0]        rep_pend;
    logic              counter_enable;
    logic              update_disable;
    logic              dir;
    logic [1:0]        center_align_select;
    logic              uif;
    logic              uie;
    logic              upd;
    logic [3:0]        chf;
    logic [3:0]        chof;
    logic [3:0]        chie;
    logic [3:0]        chde;
    logic [3:0][15:0]  cv_act;
    logic [3:0][15:0]  cv_pend;
    logic [3:0][14:0]  chctl;
    logic [4:0]        sy1;
    logic [4:0]        sy2;
    logic              itr_d;
    logic [3:0]        flt_lvl;
    logic [3:0][3:0]   flt_cnt;
    logic [3:0][2:0]   icp_cnt;
    logic [3:0]        prep;
    logic [3:0]        dma;
    logic [31:0]       prdata;
  } atc_state_t;

endpackage : atc_pkg

// File: bench/atc_timer_chk.sv
/*
  Port checker of atc_timer, bound to every instance.
  Assumes a zero-wait APB slave and the offsets of atc_defines.svh.
*/
`timescale 1ns/1ps
`include "atc_defines.svh"
module atc_timer_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic [3:0]  ch_int_req,
  input logic [3:0]  ch_dma_req,
  input logic        upd_int_req,
  input logic        update_event
);
  logic [1:0]  ctl_ff;
  logic [12:0] ie_ff;
  logic        wr;
  logic        swu;
  assign wr  = psel && penable && pwrite && pready;
  assign swu = wr && paddr == `ATC_SWEVG && pwdata[0];
  // Mirror of enable and disable bits as written by software
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctl_ff <= 2'h0;
      ie_ff  <= 13'h0;
    end
    else
    begin
      if (wr && paddr == `ATC_CTL)
        ctl_ff <= pwdata[1:0];
      if (wr && paddr == `ATC_INTEN)
        ie_ff <= pwdata[12:0];
    end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SW_UPD: assert property (swu && !ctl_ff[1] |-> ##[1:2] update_event)
    else $error("software update gave no update event");
  AST_UPD_DIS: assert property (ctl_ff[1] && $past(ctl_ff[1]) && $past(ctl_ff[1], 2)
    |-> !update_event)
    else $error("update event while updates disabled");
  AST_CEN: assert property (update_event |-> ctl_ff[0] || $past(ctl_ff[0])
    || $past(ctl_ff[0], 2) || $past(swu) || $past(swu, 2))
    else $error("update event with counter stopped");
  AST_CH_INT: assert property ((ch_int_req & ~ie_ff[4:1]) == 4'h0)
    else $error("channel interrupt while disabled");
  AST_UPD_INT: assert property (upd_int_req |-> ie_ff[0])
    else $error("update interrupt while disabled");
  AST_DMA: assert property ((ch_dma_req & ~(ie_ff[12:9] | $past(ie_ff[12:9]))) == 4'h0)
    else $error("dma request while disabled");
  AST_SW_GEN: assert property (wr && paddr == `ATC_SWEVG && pwdata[4] && ie_ff[4]
    |-> ##[1:2] ch_int_req[3])
    else $error("software channel event gave no interrupt");
  AST_SLVERR: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h3c)
    |-> pslverr && pready)
    else $error("bad address not refused");
  cover property (update_event);
  cover property (ch_int_req[0]);
  cover property (psel && penable && pslverr);
endmodule : atc_timer_chk

bind atc_timer atc_timer_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .ch_int_req(ch_int_req), .ch_dma_req(ch_dma_req), .upd_int_req(upd_int_req),
  .update_event(update_event));

// File: bench/atc_timer_test.sv
/*
  Directed testbench of atc_timer: APB tasks and counter, capture, compare runs.
  Assumes the offsets of atc_defines.svh and a checker bound to the design.
*/
`timescale 1ns/1ps
`include "atc_defines.svh"
module atc_timer_test;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  ch_in   = 4'h0;
  logic        int_trig = 1'b0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, serr, upd_int_req, update_event;
  logic [3:0]  prep, ch_int_req, ch_dma_req;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          n;
  always #12.5 pclk = ~pclk;
  atc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch_in(ch_in), .int_trigger(int_trig), .channel_prepare_signal(prep),
    .ch_int_req(ch_int_req), .ch_dma_req(ch_dma_req), .upd_int_req(upd_int_req),
    .update_event(update_event));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Cycles from one update event to the next
  task automatic gap(output int p);
    int i;
    i = 0;
    p = 1;
    while (update_event !== 1'b1 && i < 500)
    begin
      @(posedge pclk);
      i++;
    end
    @(posedge pclk);
    while (update_event !== 1'b1 && p < 500)
    begin
      @(posedge pclk);
      p++;
    end
  endtask : gap
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("unexpected at %0t: watchdog ran out", $time);
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ATC_CAR);
    chk(rdat, 32'h0000ffff);
    rd(8'h40);
    chk({31'h0, serr}, 32'h1);
    chk(rdat, 32'h0);
    // Down counting, divide by 2, two underflows per update
    wr(`ATC_CTL, 32'h10);
    wr(`ATC_PSC, 32'h1);
    wr(`ATC_CAR, 32'h4);
    wr(`ATC_REPETITION_VALUE, 32'h1);
    wr(`ATC_SWEVG, 32'h1);
    rd(`ATC_CNT);
    chk(rdat, 32'h4);
    wr(`ATC_CTL, 32'h11);
    gap(n);
    gap(n);
    chk(n, 32'd20);
    wr(`ATC_CTL, 32'h13);
    repeat (3) @(posedge pclk);
    n = 0;
    repeat (60)
    begin
      @(posedge pclk);
      if (update_event === 1'b1)
        n++;
    end
    chk(n, 32'd0);
    // Center-aligned counting, no prescaling
    wr(`ATC_CTL, 32'h20);
    wr(`ATC_PSC, 32'h0);
    wr(`ATC_CNT, 32'h3);
    wr(`ATC_SWEVG, 32'h1);
    rd(`ATC_CNT);
    chk(rdat, 32'h0);
    wr(`ATC_CTL, 32'h30);
    rd(`ATC_CTL);
    chk(rdat, 32'h20);
    wr(`ATC_CTL, 32'h21);
    gap(n);
    gap(n);
    chk(n, 32'd8);
    wr(`ATC_CTL, 32'h31);
    gap(n);
    gap(n);
    chk(n, 32'd8);
    rd(`ATC_INTF);
    chk(rdat & 32'h1, 32'h1);
    wr(`ATC_INTEN, 32'h1);
    @(posedge pclk);
    chk({31'h0, upd_int_req}, 32'h1);
    // Capture of a stopped counter on channel 0
    wr(`ATC_CTL, 32'h0);
    wr(`ATC_CNT, 32'h1234);
    wr(`ATC_INTF, 32'h0);
    wr(`ATC_INTEN, 32'h2);
    wr(8'h20, 32'h81);
    @(posedge pclk) ch_in <= 4'h1;
    repeat (8) @(posedge pclk);
    rd(8'h30);
    chk(rdat, 32'h1234);
    rd(`ATC_INTF);
    chk(rdat, 32'h2);
    chk({28'h0, ch_int_req}, 32'h1);
    wr(8'h30, 32'h5555);
    rd(8'h30);
    chk(rdat, 32'h1234);
    @(posedge pclk) ch_in <= 4'h0;
    repeat (8) @(posedge pclk);
    ch_in <= 4'h1;
    repeat (8) @(posedge pclk);
    rd(`ATC_INTF);
    chk(rdat, 32'h202);
    // Trigger source, then neighbour source on a falling edge, on channel 1
    wr(8'h24, 32'h83);
    @(posedge pclk) int_trig <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(8'h34);
    chk(rdat, 32'h1234);
    wr(8'h24, 32'hc2);
    @(posedge pclk) ch_in <= 4'h0;
    repeat (8) @(posedge pclk);
    rd(`ATC_INTF);
    chk(rdat, 32'h606);
    wr(`ATC_INTEN, 32'h0);
    // Compare on channel 2, PWM above reload on channel 3
    wr(`ATC_CAR, 32'h9);
    wr(`ATC_SWEVG, 32'h1);
    wr(8'h38, 32'h3);
    wr(8'h3c, 32'h14);
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h28, k ? 32'h08 : 32'h04);
      wr(8'h2c, k ? 32'h18 : 32'h1c);
      wr(`ATC_CTL, 32'h1);
      repeat (25) @(posedge pclk);
      chk({30'h0, prep[3:2]}, k ? 32'h0 : 32'h3);
      repeat (6) @(posedge pclk);
      chk({30'h0, prep[3:2]}, k ? 32'h0 : 32'h3);
    end
    rd(`ATC_INTF);
    chk(rdat & 32'h8, 32'h8);
    wr(`ATC_INTF, 32'h0);
    wr(`ATC_INTEN, 32'h1010);
    wr(`ATC_SWEVG, 32'h10);
    @(posedge pclk);
    chk({31'h0, ch_int_req[3]}, 32'h1);
    chk({28'h0, ch_dma_req}, 32'h8);
    give_verdict();
  end
endmodule : atc_timer_test
